// [src/ldae_pkg.sv]
package ldae_pkg;

    localparam int unsigned REG_W            = 24;
    localparam int unsigned ADDR_W           = 5;
    localparam logic [4:0]  LOCK_CFG_ADDR    = 5'h07;
    localparam logic [4:0]  ANALOG_EN_ADDR   = 5'h08;
    localparam logic [23:0] LOCK_CFG_RESET   = 24'h00_014D;
    localparam logic [23:0] ANALOG_EN_RESET  = 24'hC1_BEFF;

    localparam int unsigned CLOCK_MHZ        = 10;
    localparam int unsigned ONE_SHOT_NS      = 10;
    // Nominal time rounds down, but never below one cycle.
    localparam int unsigned ONE_SHOT_CYC_RAW = ONE_SHOT_NS * CLOCK_MHZ / 1000;
    localparam int unsigned ONE_SHOT_CYC     =
        (ONE_SHOT_CYC_RAW < 1) ? 1 : ONE_SHOT_CYC_RAW;
    localparam int unsigned WIN_CNT_W        = 11;

    typedef struct packed {
        logic [9:0] rsv_23_14;
        logic       auto_relock;
        logic       rsv_12;
        logic [1:0] timer_speed;
        logic [2:0] window_duration;
        logic       window_digital;
        logic [1:0] rsv_5_4;
        logic       internal_lock_on;
        logic [2:0] window_count_max;
    } ldae_lock_cfg_t;

    typedef struct packed {
        logic [1:0] rsv_23_22;
        logic       high_ref;
        logic       rsv_20;
        logic       fixed_div2;
        logic [7:0] rsv_18_11;
        logic       prescaler_bias_on;
        logic [3:0] rsv_9_6;
        logic       output_pad_on;
        logic       oscillator_buffer_on;
        logic       reference_buffer_on;
        logic       phase_detector_on;
        logic       charge_pump_on;
        logic       bias_on;
    } ldae_analog_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  data;
    } ldae_reg_wr_t;

    typedef enum logic [1:0] {
        LDAE_RELOCK_ARMED = 2'b01,
        LDAE_RELOCK_USED  = 2'b10
    } ldae_relock_state_t;

endpackage

// [src/ldae_lock_window.sv]
`timescale 1ns/10ps
module ldae_lock_window
    import ldae_pkg::*;
#(
    parameter int unsigned CNT_W = WIN_CNT_W
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             window_start,
    input  wire logic             window_digital,
    input  wire logic [2:0]       window_duration,
    input  wire logic [1:0]       timer_speed,
    output logic                  window_open
);

    generate
        if (CNT_W < 11)
        begin : g_width_check
            $error("ldae_lock_window: CNT_W must be at least 11");
        end
    endgenerate

    // Length in clocks: one-clock units (1 << code) times prescale when digital, else ONE_SHOT_CYC.
    function automatic logic [CNT_W-1:0] window_clocks(
        input logic       digital,
        input logic [2:0] dur,
        input logic [1:0] speed
    );
        logic [CNT_W-1:0] len;
        logic [3:0]       shift;
        len   = '0;
        // The shift needs four bits: code 7 at the slowest rate reaches ten.
        shift = {1'b0, dur} + {2'b00, speed};
        if (digital)
            len = CNT_W'(1) << shift;
        else
            len = CNT_W'(ONE_SHOT_CYC);
        return len;
    endfunction

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (window_start && count == '0)
            next_count = window_clocks(window_digital, window_duration,
                                       timer_speed);
        else if (count != '0)
            next_count = count - CNT_W'(1);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            count <= '0;
        else
            count <= next_count;
    end

    assign window_open = (count != '0);

    window_load_a: assert property (@(posedge clock) disable iff (rst)
        window_start && !window_open && window_digital |=>
        count == (CNT_W'(1) << ({1'b0, $past(window_duration)}
                  + {2'b00, $past(timer_speed)})))
        else $error("digital window loaded with wrong length");

    one_shot_a: assert property (@(posedge clock) disable iff (rst)
        window_start && !window_open && !window_digital |=>
        window_open ##1 !window_open)
        else $error("analog one-shot window not one cycle");

    fastest_half_a: assert property (@(posedge clock) disable iff (rst)
        window_start && !window_open && window_digital &&
        window_duration == 3'd0 && timer_speed == 2'd0 |=>
        window_open ##1 !window_open)
        else $error("shortest digital window not one clock");

endmodule // ldae_lock_window

// [src/ldae_regs.sv]
`timescale 1ns/10ps
module ldae_regs
    import ldae_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire ldae_reg_wr_t          reg_wr,
    input  wire logic [ADDR_W-1:0]     rd_addr,
    output logic [REG_W-1:0]           rd_data,
    output ldae_lock_cfg_t             lock_cfg,
    output ldae_analog_t               analog_cfg,
    input  wire logic                  window_start,
    output logic                       window_open,
    input  wire logic                  lock_fail,
    output logic                       relock_request,
    input  wire logic                  gpo_drive_always,
    input  wire logic                  spi_transfer_active,
    input  wire logic                  spi_address_match,
    input  wire logic                  serial_out_data,
    input  wire logic                  general_purpose_output,
    output logic                       lock_or_serial_out_pin,
    output logic                       lock_or_serial_out_pin_oe_n
);

    logic write_lock;
    logic write_analog;

    assign write_lock   = reg_wr.write && reg_wr.addr == LOCK_CFG_ADDR;
    assign write_analog = reg_wr.write && reg_wr.addr == ANALOG_EN_ADDR;

    // Register storage. Reserved fields are stored as written and steer
    // nothing, so host-owned settings read back exactly.
    ldae_lock_cfg_t next_lock_cfg;
    ldae_analog_t   next_analog_cfg;
    logic [REG_W-1:0] next_rd_data;

    always_comb
    begin
        next_lock_cfg   = lock_cfg;
        next_analog_cfg = analog_cfg;
        if (write_lock)
            next_lock_cfg = ldae_lock_cfg_t'(reg_wr.data);
        if (write_analog)
            next_analog_cfg = ldae_analog_t'(reg_wr.data);
        case (rd_addr)
            LOCK_CFG_ADDR:  next_rd_data = lock_cfg;
            ANALOG_EN_ADDR: next_rd_data = analog_cfg;
            default:        next_rd_data = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lock_cfg   <= ldae_lock_cfg_t'(LOCK_CFG_RESET);
            analog_cfg <= ldae_analog_t'(ANALOG_EN_RESET);
            rd_data    <= '0;
        end
        else
        begin
            lock_cfg   <= next_lock_cfg;
            analog_cfg <= next_analog_cfg;
            rd_data    <= next_rd_data;
        end
    end

    ldae_lock_window u_window (
        .clock           (clock),
        .rst             (rst),
        .window_start    (window_start),
        .window_digital  (lock_cfg.window_digital),
        .window_duration (lock_cfg.window_duration),
        .timer_speed     (lock_cfg.timer_speed),
        .window_open     (window_open)
    );

    // One retry per arming. Rewriting the lock register re-arms it, since
    // software then starts a fresh acquisition.
    ldae_relock_state_t relock_state;
    ldae_relock_state_t next_relock_state;
    logic               next_relock_request;

    always_comb
    begin
        next_relock_state   = relock_state;
        next_relock_request = 1'b0;
        case (relock_state)
            LDAE_RELOCK_ARMED:
            begin
                if (lock_fail && lock_cfg.auto_relock)
                begin
                    next_relock_request = 1'b1;
                    next_relock_state   = LDAE_RELOCK_USED;
                end
            end
            LDAE_RELOCK_USED:
            begin
                if (write_lock)
                    next_relock_state = LDAE_RELOCK_ARMED;
            end
            default:
                next_relock_state = LDAE_RELOCK_ARMED;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            relock_state   <= LDAE_RELOCK_ARMED;
            relock_request <= 1'b0;
        end
        else
        begin
            relock_state   <= next_relock_state;
            relock_request <= next_relock_request;
        end
    end

    // Shared pad. The enable is registered with the data so both move on
    // the same edge and the pin never glitches between owners.
    logic next_pin;
    logic next_pin_oe_n;

    always_comb
    begin
        next_pin      = spi_transfer_active ? serial_out_data
                                            : general_purpose_output;
        next_pin_oe_n = 1'b0;
        if (!analog_cfg.output_pad_on)
            next_pin_oe_n = 1'b1;
        else if (gpo_drive_always)
            next_pin_oe_n = 1'b0;
        else if (spi_transfer_active && !spi_address_match)
            next_pin_oe_n = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lock_or_serial_out_pin      <= 1'b0;
            lock_or_serial_out_pin_oe_n <= 1'b1;
        end
        else
        begin
            lock_or_serial_out_pin      <= next_pin;
            lock_or_serial_out_pin_oe_n <= next_pin_oe_n;
        end
    end

    pad_off_a: assert property (@(posedge clock) disable iff (rst)
        !analog_cfg.output_pad_on |=> lock_or_serial_out_pin_oe_n)
        else $error("pad driven while output pad disabled");

    pad_always_a: assert property (@(posedge clock) disable iff (rst)
        analog_cfg.output_pad_on && gpo_drive_always
        |=> !lock_or_serial_out_pin_oe_n)
        else $error("pad released in general-purpose mode");

    pad_shared_a: assert property (@(posedge clock) disable iff (rst)
        analog_cfg.output_pad_on && !gpo_drive_always &&
        spi_transfer_active && !spi_address_match
        |=> lock_or_serial_out_pin_oe_n)
        else $error("pad driven during unmatched transfer");

    // Checker memory of a granted retry. Only a lock register write may
    // clear it, so any request while it is set is a real second attempt.
    logic relock_seen;
    logic next_relock_seen;

    always_comb
    begin
        next_relock_seen = relock_seen;
        if (write_lock)
            next_relock_seen = 1'b0;
        else if (relock_request)
            next_relock_seen = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            relock_seen <= 1'b0;
        else
            relock_seen <= next_relock_seen;
    end

    relock_once_a: assert property (@(posedge clock) disable iff (rst)
        relock_seen |-> !relock_request)
        else $error("second relock attempt without re-arm");

    relock_pulse_a: assert property (@(posedge clock) disable iff (rst)
        relock_request |=> !relock_request)
        else $error("relock request longer than one cycle");

    relock_cause_a: assert property (@(posedge clock) disable iff (rst)
        lock_fail && lock_cfg.auto_relock &&
        relock_state == LDAE_RELOCK_ARMED |=> relock_request)
        else $error("relock not attempted after failure");

    analog_reset_a: assert property (@(posedge clock)
        rst |=> analog_cfg == ldae_analog_t'(ANALOG_EN_RESET))
        else $error("analog register reset value wrong");

    enables_reset_a: assert property (@(posedge clock)
        rst |=> analog_cfg[4:0] == 5'h1F &&
        analog_cfg.prescaler_bias_on)
        else $error("enable bits not set after reset");

    readback_a: assert property (@(posedge clock) disable iff (rst)
        write_analog ##1 (rd_addr == ANALOG_EN_ADDR && !write_analog)
        |=> rd_data == $past(reg_wr.data, 2))
        else $error("analog register readback mismatch");

    read_unmapped_a: assert property (@(posedge clock) disable iff (rst)
        rd_addr != LOCK_CFG_ADDR && rd_addr != ANALOG_EN_ADDR
        |=> rd_data == '0)
        else $error("unmapped read not zero");

    bit10_a: assert property (@(posedge clock) disable iff (rst)
        write_analog |=> analog_cfg.prescaler_bias_on
        == $past(reg_wr.data[10]))
        else $error("prescaler bias bit not stored");

endmodule // ldae_regs

// [test/ldae_host_model.sv]
`timescale 1ns/10ps
module ldae_host_model
    import ldae_pkg::*;
(
    input  wire logic             clock,
    output ldae_reg_wr_t          reg_wr,
    output logic [ADDR_W-1:0]     rd_addr,
    input  wire logic [REG_W-1:0] rd_data
);
    initial
    begin
        reg_wr  = '0;
        rd_addr = '0;
    end

    // Whole words only, reserved fields included, so a partial update can
    // never leave a stale field behind.
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clock);
        reg_wr <= {1'b1, a, d};
        @(posedge clock);
        reg_wr.write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        @(posedge clock);
        rd_addr <= a;
        @(posedge clock);
        #1;
        d = rd_data;
    endtask

    function automatic logic [23:0] analog_word(input logic [5:0] en,
        input logic pb, input int pll_mhz, input int ref_mhz);
        logic div2;
        logic href;
        div2 = pll_mhz >= 4000;
        href = ref_mhz >= 200;
        return {2'b11, href, 1'b0, div2, 8'h37, pb, 4'hB, en};
    endfunction
endmodule // ldae_host_model

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
    import ldae_pkg::*;
    logic               clock;
    logic               rst;
    logic               window_start;
    logic               lock_fail;
    logic               gpo_drive_always;
    logic               spi_transfer_active;
    logic               spi_address_match;
    logic               serial_out_data;
    logic               general_purpose_output;
    ldae_reg_wr_t       reg_wr;
    logic [ADDR_W-1:0]  rd_addr;
    logic [REG_W-1:0]   rd_data;
    logic [REG_W-1:0]   v;
    ldae_lock_cfg_t     lock_cfg;
    ldae_analog_t       analog_cfg;
    logic               window_open;
    logic               relock_request;
    logic               pin;
    logic               pin_oe_n;
    logic [4:0]         r;
    int                 n_errors;
    int                 cmp_count;
    int                 n;
    logic [4:0]         pad_tab [6] = '{5'b01101, 5'b11100, 5'b10101,
                                        5'b10110, 5'b10000, 5'b00001};

    ldae_host_model host_u (.clock(clock), .reg_wr(reg_wr),
        .rd_addr(rd_addr), .rd_data(rd_data));

    ldae_regs dut_u (.clock(clock), .rst(rst), .reg_wr(reg_wr),
        .rd_addr(rd_addr), .rd_data(rd_data), .lock_cfg(lock_cfg),
        .analog_cfg(analog_cfg), .window_start(window_start),
        .window_open(window_open), .lock_fail(lock_fail),
        .relock_request(relock_request),
        .gpo_drive_always(gpo_drive_always),
        .spi_transfer_active(spi_transfer_active),
        .spi_address_match(spi_address_match),
        .serial_out_data(serial_out_data),
        .general_purpose_output(general_purpose_output),
        .lock_or_serial_out_pin(pin),
        .lock_or_serial_out_pin_oe_n(pin_oe_n));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [4:0] a, input logic [23:0] exp);
        logic [23:0] got;
        host_u.rd(a, got);
        chk(got, exp);
    endtask

    function automatic logic [23:0] lk(input logic dig, input logic [2:0] d,
        input logic [1:0] s, input logic ar);
        return {10'h0, ar, 1'b0, s, d, dig, 6'h0D};
    endfunction

    task automatic win(input int exp);
        @(posedge clock);
        window_start <= 1'b1;
        @(posedge clock);
        window_start <= 1'b0;
        n = 0;
        #1;
        while (window_open === 1'b1 && n < 2000)
        begin
            n++;
            @(posedge clock);
            #1;
        end
        chk(24'(n), 24'(exp));
    endtask

    task automatic fail(input logic exp);
        @(posedge clock);
        lock_fail <= 1'b1;
        @(posedge clock);
        lock_fail <= 1'b0;
        #1;
        chk(24'(relock_request), 24'(exp));
        @(posedge clock);
        #1;
        chk(24'(relock_request), 24'h0);
    endtask

    initial
    begin
        {window_start, lock_fail, gpo_drive_always, spi_transfer_active} = '0;
        {spi_address_match, serial_out_data, general_purpose_output} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(lock_cfg, LOCK_CFG_RESET);
        chk(analog_cfg, ANALOG_EN_RESET);
        chk(24'({relock_request, window_open, pin_oe_n}), 24'h1);
        rchk(LOCK_CFG_ADDR, LOCK_CFG_RESET);
        rchk(ANALOG_EN_ADDR, ANALOG_EN_RESET);
        rchk(5'h1F, 24'h00_0000);
        $display("test reset done");
        for (int i = 0; i < 7; i++)
        begin
            v = host_u.analog_word(i < 6 ? ~(6'd1 << i) : 6'h3F, i != 6,
                3999 + i, 199 + i);
            host_u.wr(ANALOG_EN_ADDR, v);
            chk(analog_cfg, v);
            chk(24'({analog_cfg.fixed_div2, analog_cfg.high_ref}),
                24'({2{i != 0}}));
            rchk(ANALOG_EN_ADDR, v);
        end
        host_u.wr(5'h09, 24'h00_0000);
        rchk(ANALOG_EN_ADDR, v);
        $display("test analog done");
        for (int d = 0; d < 8; d++)
        begin
            host_u.wr(LOCK_CFG_ADDR, lk(1'b1, 3'(d), 2'd0, 1'b0));
            rchk(LOCK_CFG_ADDR, lk(1'b1, 3'(d), 2'd0, 1'b0));
            win(1 << d);
        end
        for (int s = 1; s < 4; s++)
        begin
            host_u.wr(LOCK_CFG_ADDR, lk(1'b1, 3'd2, 2'(s), 1'b0));
            win(4 << s);
        end
        host_u.wr(LOCK_CFG_ADDR, lk(1'b1, 3'd7, 2'd3, 1'b0));
        win(1024);
        host_u.wr(LOCK_CFG_ADDR, lk(1'b0, 3'd7, 2'd3, 1'b0));
        win(ONE_SHOT_CYC);
        $display("test window done");
        host_u.wr(LOCK_CFG_ADDR, lk(1'b1, 3'd2, 2'd0, 1'b1));
        fail(1'b1);
        fail(1'b0);
        host_u.wr(LOCK_CFG_ADDR, lk(1'b1, 3'd2, 2'd0, 1'b0));
        fail(1'b0);
        host_u.wr(LOCK_CFG_ADDR, lk(1'b1, 3'd2, 2'd0, 1'b1));
        fail(1'b1);
        $display("test relock done");
        for (int i = 0; i < 6; i++)
        begin
            r = pad_tab[i];
            host_u.wr(ANALOG_EN_ADDR,
                host_u.analog_word({r[4], 5'h1F}, 1'b1, 100, 10));
            @(posedge clock);
            {gpo_drive_always, spi_transfer_active,
             spi_address_match} <= r[3:1];
            serial_out_data <= i[0];
            general_purpose_output <= ~i[0];
            repeat (2) @(posedge clock);
            #1;
            chk(24'(pin_oe_n), 24'(r[0]));
            if (!r[0])
                chk(24'(pin), 24'(r[2] ? i[0] : !i[0]));
        end
        $display("test pad done");
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(lock_cfg, LOCK_CFG_RESET);
        chk(analog_cfg, ANALOG_EN_RESET);
        chk(24'({relock_request, window_open, pin_oe_n}), 24'h1);
        rchk(ANALOG_EN_ADDR, ANALOG_EN_RESET);
        $display("test mid reset done");
        close_out();
    end

    // All tests together take well under two thousand cycles.
    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule // tb
